// ===== hw/bbswp_remap.sv
`timescale 1ns/1ps
// top-block swap address remapper
module bbswp_remap
  import bbswp_pkg::*;
(
  // clock and resets
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              battery_well_reset_n_i,
  input  wire logic              platform_reset_n_i,
  // configuration
  input  wire logic [SIZE_W-1:0] size_sel_i,
  input  wire logic              target_is_hub_i,
  input  wire logic              swap_strap_i,
  // software control
  input  wire logic              swap_wr_i,
  input  wire logic              swap_wdata_i,
  input  wire logic              lock_wr_i,
  // host cycle in
  input  wire logic              cyc_valid_i,
  input  wire logic [ADDR_W-1:0] cyc_addr_i,
  // cycle out to flash
  output logic                   cyc_valid_o,
  output logic [ADDR_W-1:0]      cyc_addr_o,
  output logic                   cyc_swapped_o,
  // status
  output logic                   swap_en_o,
  output logic                   lock_o
);

  logic [1:0]        well_rst_sync_q;
  logic [1:0]        plat_rst_sync_q;
  logic [1:0]        strap_sync_q;
  logic              well_rst;
  logic              plat_rst;
  logic              swap_q;
  logic              lock_q;
  logic              swap_eff;
  bbswp_tgt_t        tgt;
  logic [SIZE_W-1:0] code;
  int unsigned       sel;
  logic [ADDR_W-1:0] mask;
  logic              in_region;
  logic [ADDR_W-1:0] addr_d;
  logic              swapped_d;
  logic              valid_q;
  logic [ADDR_W-1:0] addr_q;
  logic              swapped_q;
  logic              swap_en_q;
  logic              lock_oq;

  // two-stage synchronisers for pins from outside the clock
  always_ff @(posedge ref_clk_i)
  begin
    well_rst_sync_q <= {well_rst_sync_q[0], ~battery_well_reset_n_i};
    plat_rst_sync_q <= {plat_rst_sync_q[0], ~platform_reset_n_i};
    strap_sync_q    <= {strap_sync_q[0], swap_strap_i};
  end

  // well reset comes only from its own pin; sys_rst_i never touches the well bits
  assign well_rst = well_rst_sync_q[1];
  // platform reset only clears the pipeline, never the well bits
  assign plat_rst = sys_rst_i | plat_rst_sync_q[1];

  bbswp_well_bits u_well (
    .ref_clk_i    (ref_clk_i),
    .well_rst_i   (well_rst),
    .swap_wr_i    (swap_wr_i),
    .swap_wdata_i (swap_wdata_i),
    .lock_wr_i    (lock_wr_i),
    .strap_sync_i (strap_sync_q[1]),
    .swap_q_o     (swap_q),
    .lock_q_o     (lock_q)
  );

  // strap reads as swap even before the register has followed
  assign swap_eff = swap_q | strap_sync_q[1];

  // hub is fixed at 64 KB, serial flash uses the size code
  assign tgt  = target_is_hub_i ? BBSWP_TGT_FMH : BBSWP_TGT_SPI;
  assign code = (tgt == BBSWP_TGT_FMH) ? SIZE_64K : size_sel_i;
  assign sel  = bbswp_sel_bit(code);
  assign mask = bbswp_top_mask(sel);

  // region check and single-bit inversion
  always_comb
  begin
    in_region = ((cyc_addr_i & mask) == mask);
    addr_d    = cyc_addr_i;
    swapped_d = 1'b0;
    case (tgt)
      BBSWP_TGT_FMH, BBSWP_TGT_SPI:
      begin
        if (swap_eff && in_region)
        begin
          addr_d[sel] = ~cyc_addr_i[sel];
          swapped_d   = 1'b1;
        end
        // swap off leaves every bit as given
      end
      default:
      begin
        addr_d    = cyc_addr_i;
        swapped_d = 1'b0;
      end
    endcase
  end

  // registered cycle output
  always_ff @(posedge ref_clk_i)
  begin
    if (plat_rst)
    begin
      valid_q   <= 1'b0;
      addr_q    <= '0;
      swapped_q <= 1'b0;
    end
    else
    begin
      valid_q   <= cyc_valid_i;
      addr_q    <= addr_d;
      swapped_q <= cyc_valid_i & swapped_d;
    end
  end

  // registered status
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      swap_en_q <= 1'b0;
      lock_oq   <= 1'b0;
    end
    else
    begin
      swap_en_q <= swap_eff;
      lock_oq   <= lock_q;
    end
  end

  assign cyc_valid_o   = valid_q;
  assign cyc_addr_o    = addr_q;
  assign cyc_swapped_o = swapped_q;
  assign swap_en_o     = swap_en_q;
  assign lock_o        = lock_oq;

endmodule

// ===== hw/bbswp_well_bits.sv
`timescale 1ns/1ps
// battery-well swap and lock bits, reset only by the well reset
module bbswp_well_bits
  import bbswp_pkg::*;
(
  // clock and well reset
  input  wire logic ref_clk_i,
  input  wire logic well_rst_i,
  // software write and strap
  input  wire logic swap_wr_i,
  input  wire logic swap_wdata_i,
  input  wire logic lock_wr_i,
  input  wire logic strap_sync_i,
  // state
  output logic      swap_q_o,
  output logic      lock_q_o
);

  logic swap_q;
  logic lock_q;

  // swap bit: held in the battery well, strap forces it to one
  always_ff @(posedge ref_clk_i)
  begin
    if (well_rst_i)
      swap_q <= SWAP_RST_VAL;
    else if (strap_sync_i)
      swap_q <= 1'b1;
    else if (swap_wr_i && !lock_q)
      swap_q <= swap_wdata_i;
  end

  // lock bit: set once, cleared only by the well reset
  always_ff @(posedge ref_clk_i)
  begin
    if (well_rst_i)
      lock_q <= LOCK_RST_VAL;
    else if (lock_wr_i)
      lock_q <= 1'b1;
  end

  assign swap_q_o = swap_q;
  assign lock_q_o = lock_q;

endmodule

// ===== inc/bbswp_pkg.sv
// Behaviour
// - With swapping on and a firmware hub target, address bit 16 is inverted for the top two 64 KB blocks.
// - Firmware hub swap maps FFFF_0000h-FFFF_FFFFh onto FFFE_0000h-FFFE_FFFFh and back.
// - With the swap bit at 0 and the strap deasserted, firmware hub addresses keep bit 16 unchanged.
// - With the swap bit at 0 and the strap deasserted, serial flash addresses pass with no bit inverted, whatever the size code.
// - For serial flash a 3-bit size code picks the inverted line, 000 for 64 KB up to 111 for 8 MB.
// - Size code 000 with swapping on exchanges FFFF_0000h-FFFF_FFFFh and FFFE_0000h-FFFE_FFFFh.
// - Size code 111 with swapping on exchanges FF80_0000h-FFFF_FFFFh and FF00_0000h-FF7F_FFFFh.
// - The swap bit clears on the battery well reset and survives a platform reset.
// - The swap bit lives in the battery-backed well so swapping survives a main power loss.
// - While the strap is asserted the swap bit reads 1 and software cannot clear it.
package bbswp_pkg;

  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned SIZE_W       = 3;
  // bit that selects a 64 KB half; size code adds to it
  localparam int unsigned BASE_SEL_BIT = 16;
  localparam logic [SIZE_W-1:0] SIZE_64K = 3'h0;
  localparam logic [SIZE_W-1:0] SIZE_8M  = 3'h7;
  localparam logic SWAP_RST_VAL = 1'b0;
  localparam logic LOCK_RST_VAL = 1'b0;

  typedef enum logic [1:0] {
    BBSWP_TGT_SPI = 2'b01,
    BBSWP_TGT_FMH = 2'b10
  } bbswp_tgt_t;

  // bit position that picks the half of the doubled region
  function automatic int unsigned bbswp_sel_bit(input logic [SIZE_W-1:0] code);
    bbswp_sel_bit = BASE_SEL_BIT + int'(code);
  endfunction

  // mask of bits above the selector that must all be ones
  function automatic logic [ADDR_W-1:0] bbswp_top_mask(input int unsigned sel);
    logic [ADDR_W-1:0] m;
    m = '1;
    bbswp_top_mask = m << (sel + 1);
  endfunction

endpackage

// ===== test/bbswp_flash_model.sv
`timescale 1ns/1ps
// flash side: takes every cycle handed to it
module bbswp_flash_model
(
  input  wire logic ref_clk_i,
  input  wire logic cyc_valid_i,
  output int        seen_cnt_o
);
  initial seen_cnt_o = 0;
  // count accepted beats
  always @(posedge ref_clk_i)
  begin
    if (cyc_valid_i === 1'b1)
      seen_cnt_o <= seen_cnt_o + 1;
  end
endmodule

// ===== test/bbswp_remap_assertions.sv
`timescale 1ns/1ps
// port-level checks of the swap remapper
module bbswp_remap_assertions
  import bbswp_pkg::*;
(
  // watched ports
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [SIZE_W-1:0] size_sel_i,
  input wire logic              target_is_hub_i,
  input wire logic              swap_strap_i,
  input wire logic              swap_wr_i,
  input wire logic              swap_wdata_i,
  input wire logic              cyc_valid_i,
  input wire logic [ADDR_W-1:0] cyc_addr_i,
  input wire logic              cyc_valid_o,
  input wire logic [ADDR_W-1:0] cyc_addr_o,
  input wire logic              cyc_swapped_o,
  input wire logic              swap_en_o,
  input wire logic              lock_o
);
  logic [ADDR_W-1:0] top_m;
  logic [ADDR_W-1:0] flip_m;
  logic              in_rgn;
  // region mask and the one bit to invert
  assign top_m  = target_is_hub_i ? 32'hfffe_0000 : 32'hffff_ffff << (17 + size_sel_i);
  assign flip_m = target_is_hub_i ? 32'h0001_0000 : 32'h0001_0000 << size_sel_i;
  assign in_rgn = (cyc_addr_i & top_m) == top_m;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  vld_lat_a: assert property (cyc_valid_i |=> cyc_valid_o)
    else $error("valid lost");
  // swap_en_o after the edge shows the swap state that the cycle was launched with
  remap_a: assert property (cyc_valid_i |=>
    cyc_addr_o == ((swap_en_o && $past(in_rgn)) ? $past(cyc_addr_i ^ flip_m) : $past(cyc_addr_i)))
    else $error("remap wrong");
  keep_out_a: assert property (cyc_valid_i && !in_rgn |=> cyc_addr_o == $past(cyc_addr_i))
    else $error("outside changed");
  swap_flag_a: assert property (cyc_valid_i |=> cyc_swapped_o == (swap_en_o && $past(in_rgn)))
    else $error("flag wrong");
  no_swap_a: assert property (cyc_valid_i |=> swap_en_o || !cyc_swapped_o)
    else $error("swapped while off");
  strap_on_a: assert property (swap_strap_i [*3] |=> swap_en_o)
    else $error("strap ignored");
  swap_set_a: assert property (swap_wr_i && swap_wdata_i && !lock_o && !swap_en_o |-> ##2 swap_en_o)
    else $error("set lost");
  lock_hold_a: assert property (lock_o |=> lock_o)
    else $error("lock dropped");
  lock_wr_a: assert property (lock_o && swap_wr_i |=> ##1 $stable(swap_en_o))
    else $error("locked write took");
  cover property (cyc_valid_i && swap_en_o && in_rgn && target_is_hub_i);
  cover property (cyc_valid_i && swap_en_o && in_rgn && size_sel_i == SIZE_8M);
  cover property (lock_o && swap_wr_i);
endmodule

// ===== test/bbswp_remap_tb.sv
`timescale 1ns/1ps
// stimulus and checks for the swap remapper
module bbswp_remap_tb import bbswp_pkg::*;;
  logic        ref_clk_i = 0, sys_rst_i = 1, battery_well_reset_n_i = 0;
  logic        platform_reset_n_i = 1, target_is_hub_i = 0, swap_strap_i = 0;
  logic        swap_wr_i = 0, swap_wdata_i = 0, lock_wr_i = 0, cyc_valid_i = 0;
  logic [2:0]  size_sel_i = 0;
  logic [31:0] cyc_addr_i = 0, cyc_addr_o;
  logic        cyc_valid_o, cyc_swapped_o, swap_en_o, lock_o;
  int          err_total = 0, checks_done = 0, seen;
  bbswp_remap u_dut (.*);
  bbswp_flash_model u_flash (.ref_clk_i(ref_clk_i), .cyc_valid_i(cyc_valid_o), .seen_cnt_o(seen));
  // clock
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one host cycle, result one edge later
  task automatic cyc(input logic [31:0] a, input logic [31:0] e);
    @(posedge ref_clk_i) #1 cyc_valid_i = 1;
    cyc_addr_i = a;
    @(posedge ref_clk_i) #1 cyc_valid_i = 0;
    chk(cyc_addr_o, e);
    chkb(cyc_swapped_o, a != e);
  endtask
  // software write pulse, then let it settle
  task automatic wr(input logic sw, input logic lk, input logic d);
    @(posedge ref_clk_i) #1 swap_wr_i = sw;
    lock_wr_i = lk;
    swap_wdata_i = d;
    @(posedge ref_clk_i) #1 swap_wr_i = 0;
    lock_wr_i = 0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // watchdog
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    err_total++;
    stop_test();
  end
  // test sequence
  initial
  begin
    pause(2);
    sys_rst_i = 0;
    pause(3);
    battery_well_reset_n_i = 1;
    target_is_hub_i = 1;
    cyc(32'hffff_1234, 32'hffff_1234);
    target_is_hub_i = 0;
    size_sel_i = 3'h7;
    cyc(32'hffc0_0000, 32'hffc0_0000);
    wr(1, 0, 1);
    target_is_hub_i = 1;
    cyc(32'hffff_1234, 32'hfffe_1234);
    cyc(32'hfffe_00aa, 32'hffff_00aa);
    cyc(32'hfffd_0000, 32'hfffd_0000);
    target_is_hub_i = 0;
    for (int k = 0; k < 8; k++)
    begin
      size_sel_i = 3'(k);
      cyc(32'hffff_fff0, 32'hffff_fff0 ^ (32'h0001_0000 << k));
    end
    cyc(32'hff00_0010, 32'hff80_0010);
    cyc(32'hfe00_0000, 32'hfe00_0000);
    platform_reset_n_i = 0;
    pause(4);
    platform_reset_n_i = 1;
    pause(4);
    chkb(swap_en_o, 1);
    battery_well_reset_n_i = 0;
    pause(5);
    battery_well_reset_n_i = 1;
    pause(4);
    chkb(swap_en_o, 0);
    swap_strap_i = 1;
    pause(4);
    chkb(swap_en_o, 1);
    wr(1, 0, 0);
    chkb(swap_en_o, 1);
    swap_strap_i = 0;
    pause(4);
    wr(1, 0, 0);
    chkb(swap_en_o, 0);
    wr(0, 1, 0);
    chkb(lock_o, 1);
    wr(1, 0, 1);
    chkb(swap_en_o, 0);
    chk(seen, 32'd15);
    stop_test();
  end
endmodule
bind bbswp_remap bbswp_remap_assertions u_chk (.*);
